// *** iot_timer.sv ***
// 16-bit io timer: free-run counter, two compare outputs, two input captures
`timescale 1ns/10ps
`default_nettype none
`include "iot_params.svh"

// Behaviour
// - 16-bit prescaled free-run counter shared by channels
// - count clock divides by 4,16,32,64
// - interrupt on overflow and compare 0 or compare 1 match
// - counter zeroed by reset, clear bit, compare 0 match in clear mode
// - counter reads live, write loads it
// - compare match inverts output, may interrupt
// - each compare has own pin and flag
// - paired mode: both compares toggle one pin
// - software presets compare output levels
// - selected capture edge latches counter value
// - capture edge rising, falling or both
// - two independent capture channels with interrupts
// - capture request may start data transfer
module iot_timer #(
	parameter int CW = 16	// counter width
) (
	input  wire logic             MCLK,
	input  wire logic             RSTN,
	input  wire logic [7:0]       ADDR,
	input  wire logic [15:0]      WDATA,
	input  wire logic             WR,
	input  wire logic             RD,
	output logic      [15:0]      RDATA,
	input  wire logic             CAP_IN0,
	input  wire logic             CAP_IN1,
	output logic                  CMP_OUT0,
	output logic                  CMP_OUT1,
	output logic                  IRQ,
	output logic                  XFER_REQ0,
	output logic                  XFER_REQ1
);
	import iot_pkg::*;

	// ***************************************************
	// storage
	// ***************************************************
	logic [CW-1:0] count_ff;	// free-run count
	logic [5:0]    pre_ff;	// prescaler
	logic [4:0]    tctl_ff;	// timer control
	logic [CW-1:0] cmp_ff [2];	// compare values
	logic [4:0]    octl_ff;	// compare control
	logic [1:0]    pin_ff;	// compare output latches
	logic [CW-1:0] cap_ff [2];	// capture values
	logic [5:0]    ictl_ff;	// capture control
	logic [4:0]    stat_ff;	// sticky flags
	logic [4:0]    mask_ff;	// interrupt enables
	logic [1:0]    in_s1_ff;	// sync stage one
	logic [1:0]    in_s2_ff;	// sync stage two
	logic [1:0]    in_old_ff;	// previous synced level
	logic [15:0]   rdata_ff;	// read data
	logic [1:0]    xfer_ff;	// transfer request pulses

	// control decode
	logic          wr_cnt, wr_tctl, wr_stat, tick, ovf, clr_match;
	logic [1:0]    match, hit, toggle;
	logic [5:0]    div_top;
	logic [4:0]    ev;

	assign wr_cnt  = WR && (ADDR == `IOT_ADR_COUNT);
	assign wr_tctl = WR && (ADDR == `IOT_ADR_TCTL);
	assign wr_stat = WR && (ADDR == `IOT_ADR_STAT);

	// edge test for one capture channel
	function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic old);
		logic r;
		logic f;
		r = now & ~old;
		f = ~now & old;
		case (iot_edge_t'(sel))
			IOT_EDGE_RISE: edge_hit = r;
			IOT_EDGE_FALL: edge_hit = f;
			IOT_EDGE_BOTH: edge_hit = r | f;
			default:       edge_hit = 1'b0;
		endcase
	endfunction : edge_hit

	// ***************************************************
	// prescaler
	// ***************************************************
	// terminal count from selected division
	always_comb begin
		case (iot_div_t'(tctl_ff[`IOT_TCTL_DIV_LSB +: 2]))
			IOT_DIV_4:  div_top = `IOT_DIV4_CNT;
			IOT_DIV_16: div_top = `IOT_DIV16_CNT;
			IOT_DIV_32: div_top = `IOT_DIV32_CNT;
			default:    div_top = `IOT_DIV64_CNT;
		endcase
	end

	assign tick = !tctl_ff[`IOT_TCTL_HALT] && (pre_ff >= div_top);

	// prescaler runs unless halted
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			pre_ff <= 6'h00;
		end else if (tctl_ff[`IOT_TCTL_HALT] || tick) begin
			pre_ff <= 6'h00;
		end else begin
			pre_ff <= pre_ff + 6'h01;
		end
	end

	// ***************************************************
	// free-run counter
	// ***************************************************
	assign match     = {count_ff == cmp_ff[1], count_ff == cmp_ff[0]};
	assign hit       = tick ? match : 2'b00;	// one match event per count step
	assign clr_match = hit[0] && tctl_ff[`IOT_TCTL_CLRMD];
	assign ovf       = tick && (count_ff == {CW{1'b1}});

	// count up, zero or load; a software load wins
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			count_ff <= '0;
		end else if (wr_cnt) begin
			count_ff <= WDATA[CW-1:0];
		end else if (wr_tctl && WDATA[`IOT_TCTL_ZERO]) begin
			count_ff <= '0;
		end else if (clr_match) begin
			count_ff <= '0;
		end else if (tick) begin
			count_ff <= count_ff + 1'b1;
		end
	end

	// timer control; the zero request bit is not stored
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			tctl_ff <= `IOT_TCTL_RST;
		end else if (wr_tctl) begin
			tctl_ff <= {1'b0, WDATA[3:0]};
		end
	end

	// ***************************************************
	// output compare
	// ***************************************************
	// channel 1 toggles pin 0 instead of pin 1 when paired
	assign toggle[0] = (hit[0] && octl_ff[`IOT_OCTL_EN0])
		|| (octl_ff[`IOT_OCTL_PAIR] && hit[1] && octl_ff[`IOT_OCTL_EN1]);
	assign toggle[1] = !octl_ff[`IOT_OCTL_PAIR] && hit[1] && octl_ff[`IOT_OCTL_EN1];

	// compare registers
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			cmp_ff[0] <= '0;
			cmp_ff[1] <= '0;
		end else if (WR && ADDR == `IOT_ADR_CMP0) begin
			cmp_ff[0] <= WDATA[CW-1:0];
		end else if (WR && ADDR == `IOT_ADR_CMP1) begin
			cmp_ff[1] <= WDATA[CW-1:0];
		end
	end

	// compare control
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			octl_ff <= `IOT_OCTL_RST;
		end else if (WR && ADDR == `IOT_ADR_OCTL) begin
			octl_ff <= WDATA[4:0];
		end
	end

	// output latches: preset by write, inverted on match
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			pin_ff <= 2'b00;
		end else if (WR && ADDR == `IOT_ADR_OCTL) begin
			pin_ff <= WDATA[`IOT_OCTL_LVL1:`IOT_OCTL_LVL0];
		end else begin
			pin_ff <= pin_ff ^ toggle;
		end
	end

	assign CMP_OUT0 = pin_ff[0];
	assign CMP_OUT1 = pin_ff[1];

	// ***************************************************
	// input capture
	// ***************************************************
	// two-stage synchroniser, then edge history
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			in_s1_ff  <= 2'b00;
			in_s2_ff  <= 2'b00;
			in_old_ff <= 2'b00;
		end else begin
			in_s1_ff  <= {CAP_IN1, CAP_IN0};
			in_s2_ff  <= in_s1_ff;
			in_old_ff <= in_s2_ff;
		end
	end

	logic [1:0] cap_hit;	// selected edge seen
	assign cap_hit[0] = edge_hit(ictl_ff[`IOT_ICTL_EDG0 +: 2], in_s2_ff[0], in_old_ff[0]);
	assign cap_hit[1] = edge_hit(ictl_ff[`IOT_ICTL_EDG1 +: 2], in_s2_ff[1], in_old_ff[1]);

	// capture registers are read-only
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			cap_ff[0] <= '0;
			cap_ff[1] <= '0;
		end else begin
			if (cap_hit[0]) begin
				cap_ff[0] <= count_ff;
			end
			if (cap_hit[1]) begin
				cap_ff[1] <= count_ff;
			end
		end
	end

	// capture control
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			ictl_ff <= `IOT_ICTL_RST;
		end else if (WR && ADDR == `IOT_ADR_ICTL) begin
			ictl_ff <= WDATA[5:0];
		end
	end

	// transfer request pulse instead of an interrupt
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			xfer_ff <= 2'b00;
		end else begin
			xfer_ff <= cap_hit & ictl_ff[`IOT_ICTL_XFER1:`IOT_ICTL_XFER0];
		end
	end

	assign XFER_REQ0 = xfer_ff[0];
	assign XFER_REQ1 = xfer_ff[1];

	// ***************************************************
	// interrupt status and mask
	// ***************************************************
	assign ev = {cap_hit[1] & ~ictl_ff[`IOT_ICTL_XFER1],
		cap_hit[0] & ~ictl_ff[`IOT_ICTL_XFER0], hit[1], hit[0], ovf};

	// sticky flags, write one to clear, set beats clear
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			stat_ff <= `IOT_ST_RST;
		end else begin
			stat_ff <= (stat_ff & ~(wr_stat ? WDATA[4:0] : 5'h00)) | ev;
		end
	end

	// interrupt enables
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			mask_ff <= 5'h00;
		end else if (WR && ADDR == `IOT_ADR_MASK) begin
			mask_ff <= WDATA[4:0];
		end
	end

	assign IRQ = |(stat_ff & mask_ff);

	// ***************************************************
	// read port
	// ***************************************************
	// read data stand one cycle after the strobe
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			rdata_ff <= 16'h0000;
		end else if (RD) begin
			case (ADDR)
				`IOT_ADR_COUNT: rdata_ff <= count_ff;
				`IOT_ADR_TCTL:  rdata_ff <= {11'h000, tctl_ff};
				`IOT_ADR_CMP0:  rdata_ff <= cmp_ff[0];
				`IOT_ADR_CMP1:  rdata_ff <= cmp_ff[1];
				`IOT_ADR_OCTL:  rdata_ff <= {11'h000, octl_ff[4:2], pin_ff};
				`IOT_ADR_CAP0:  rdata_ff <= cap_ff[0];
				`IOT_ADR_CAP1:  rdata_ff <= cap_ff[1];
				`IOT_ADR_ICTL:  rdata_ff <= {10'h000, ictl_ff};
				`IOT_ADR_STAT:  rdata_ff <= {11'h000, stat_ff};
				`IOT_ADR_MASK:  rdata_ff <= {11'h000, mask_ff};
				default:        rdata_ff <= 16'h0000;	// unmapped reads zero
			endcase
		end else begin
			rdata_ff <= 16'h0000;
		end
	end

	assign RDATA = rdata_ff;

	// ***************************************************
	// checks
	// ***************************************************
	sequence s_tick_top;
		tick && count_ff == 16'hffff;
	endsequence

	a_count_step: assert property (@(posedge MCLK) disable iff (!RSTN)
		tick && !WR && !clr_match |=> count_ff == $past(count_ff) + 16'h0001)
		else $error("counter did not step on tick");
	a_halt_hold: assert property (@(posedge MCLK) disable iff (!RSTN)
		tctl_ff[`IOT_TCTL_HALT] && !WR |=> count_ff == $past(count_ff))
		else $error("halted counter moved");
	a_div_four: assert property (@(posedge MCLK) disable iff (!RSTN)
		tick && tctl_ff[1:0] == 2'h0 && !wr_tctl ##1 !wr_tctl [*3] |=> pre_ff == `IOT_DIV4_CNT)
		else $error("divide by four spacing wrong");
	a_ovf_flag: assert property (@(posedge MCLK) disable iff (!RSTN)
		s_tick_top |=> stat_ff[`IOT_ST_OVF])
		else $error("overflow flag missing");
	a_zero_req: assert property (@(posedge MCLK) disable iff (!RSTN)
		wr_tctl && WDATA[`IOT_TCTL_ZERO] |=> count_ff == 16'h0000)
		else $error("zero request ignored");
	a_cnt_load: assert property (@(posedge MCLK) disable iff (!RSTN)
		wr_cnt |=> count_ff == $past(WDATA))
		else $error("counter load failed");
	a_cmp_toggle: assert property (@(posedge MCLK) disable iff (!RSTN)
		hit[0] && octl_ff[`IOT_OCTL_EN0] && !WR |=> CMP_OUT0 != $past(CMP_OUT0))
		else $error("compare 0 did not invert");
	a_pair_mode: assert property (@(posedge MCLK) disable iff (!RSTN)
		octl_ff[`IOT_OCTL_PAIR] && !WR |=> CMP_OUT1 == $past(CMP_OUT1))
		else $error("paired pin 1 moved");
	a_cap_latch: assert property (@(posedge MCLK) disable iff (!RSTN)
		cap_hit[0] |=> cap_ff[0] == $past(count_ff))
		else $error("capture 0 wrong value");
	a_irq_gate: assert property (@(posedge MCLK) disable iff (!RSTN)
		mask_ff == 5'h00 |-> !IRQ)
		else $error("masked interrupt raised");
endmodule : iot_timer
`default_nettype wire

// *** iot_params.svh ***
// register offsets, field positions, reset values and timing counts of the io timer
`ifndef IOT_PARAMS_SVH
`define IOT_PARAMS_SVH

// ***************************************************
// register word addresses
// ***************************************************
`define IOT_ADR_COUNT     8'h00
`define IOT_ADR_TCTL      8'h01
`define IOT_ADR_CMP0      8'h02
`define IOT_ADR_CMP1      8'h03
`define IOT_ADR_OCTL      8'h04
`define IOT_ADR_CAP0      8'h05
`define IOT_ADR_CAP1      8'h06
`define IOT_ADR_ICTL      8'h07
`define IOT_ADR_STAT      8'h08
`define IOT_ADR_MASK      8'h09

// ***************************************************
// timer control fields
// ***************************************************
`define IOT_TCTL_DIV_LSB  0
`define IOT_TCTL_CLRMD    2
`define IOT_TCTL_HALT     3
`define IOT_TCTL_ZERO     4
`define IOT_TCTL_RST      5'h08

// ***************************************************
// compare control fields
// ***************************************************
`define IOT_OCTL_LVL0     0
`define IOT_OCTL_LVL1     1
`define IOT_OCTL_EN0      2
`define IOT_OCTL_EN1      3
`define IOT_OCTL_PAIR     4
`define IOT_OCTL_RST      5'h00

// ***************************************************
// capture control fields: edge selects, transfer enables, reset value
// ***************************************************
`define IOT_ICTL_EDG0     0
`define IOT_ICTL_EDG1     2
`define IOT_ICTL_XFER0    4
`define IOT_ICTL_XFER1    5
`define IOT_ICTL_RST      6'h00

// ***************************************************
// status bits: overflow, compare 0/1, capture 0/1
// ***************************************************
`define IOT_ST_OVF        0
`define IOT_ST_CMP0       1
`define IOT_ST_CMP1       2
`define IOT_ST_CAP0       3
`define IOT_ST_CAP1       4
`define IOT_ST_RST        5'h00

// ***************************************************
// prescaler terminal counts (machine clock divided by 4,16,32,64)
// ***************************************************
`define IOT_DIV4_CNT      6'h03
`define IOT_DIV16_CNT     6'h0f
`define IOT_DIV32_CNT     6'h1f
`define IOT_DIV64_CNT     6'h3f

`endif

// *** iot_pkg.sv ***
// types shared by the io timer
package iot_pkg;
	// capture edge selection
	typedef enum logic [1:0] {
		IOT_EDGE_OFF  = 2'h0,
		IOT_EDGE_RISE = 2'h1,
		IOT_EDGE_FALL = 2'h2,
		IOT_EDGE_BOTH = 2'h3
	} iot_edge_t;
	// prescaler division selection
	typedef enum logic [1:0] {
		IOT_DIV_4  = 2'h0,
		IOT_DIV_16 = 2'h1,
		IOT_DIV_32 = 2'h2,
		IOT_DIV_64 = 2'h3
	} iot_div_t;
endpackage : iot_pkg

// *** iot_pins.sv ***
// pin-side partner of the io timer: capture input drivers, compare toggle counters
`timescale 1ns/10ps
`default_nettype none
module iot_pins (
	input  wire logic       mclk,
	input  wire logic       rstn,
	input  wire logic       cmp0,
	input  wire logic       cmp1,
	output var  logic       cap0,
	output var  logic       cap1,
	output var  logic [7:0] tog0,
	output var  logic [7:0] tog1
);
	logic c0_ff;	// last seen level of compare pin 0
	logic c1_ff;	// last seen level of compare pin 1
	// ****************
	// toggle counting on the compare pins
	// ****************
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			c0_ff <= 1'b0;
			c1_ff <= 1'b0;
			tog0  <= 8'h00;
			tog1  <= 8'h00;
		end else begin
			c0_ff <= cmp0;
			c1_ff <= cmp1;
			tog0  <= tog0 + {7'h00, cmp0 ^ c0_ff};
			tog1  <= tog1 + {7'h00, cmp1 ^ c1_ff};
		end
	end
	// capture inputs idle low
	initial begin
		cap0 = 1'b0;
		cap1 = 1'b0;
	end
	// move one capture pin just after a clock edge, then hold it
	task automatic set_pin(input int ch, input logic lvl);
		@(posedge mclk);
		if (ch == 0) cap0 <= lvl;
		else cap1 <= lvl;
	endtask : set_pin
endmodule : iot_pins
`default_nettype wire

// *** testbench.sv ***
// self-checking testbench of the io timer
`timescale 1ns/10ps
`default_nettype none
`include "iot_params.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
	import iot_pkg::*;
	logic        MCLK, RSTN, WR, RD, CAP_IN0, CAP_IN1;
	logic [7:0]  ADDR;
	logic [15:0] WDATA, RDATA, v, w;
	logic        CMP_OUT0, CMP_OUT1, IRQ, XFER_REQ0, XFER_REQ1;
	logic [7:0]  tog0, tog1, t0, t1;
	int          err_total, compares, xfer_n, x0, xfer1_n, x1;
	int          dv[4] = '{4, 16, 32, 64};	// prescaler ratios by div code
	iot_timer iot_timer_i (.MCLK(MCLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
		.RD(RD), .RDATA(RDATA), .CAP_IN0(CAP_IN0), .CAP_IN1(CAP_IN1), .CMP_OUT0(CMP_OUT0),
		.CMP_OUT1(CMP_OUT1), .IRQ(IRQ), .XFER_REQ0(XFER_REQ0), .XFER_REQ1(XFER_REQ1));
	iot_pins iot_pins_i (.mclk(MCLK), .rstn(RSTN), .cmp0(CMP_OUT0), .cmp1(CMP_OUT1),
		.cap0(CAP_IN0), .cap1(CAP_IN1), .tog0(tog0), .tog1(tog1));
	// 200 MHz clock
	always #2.5 MCLK = ~MCLK;
	// count transfer request pulses mid-cycle, where the registered outputs have settled
	always @(negedge MCLK) begin
		if (XFER_REQ0 === 1'b1) xfer_n++;
		if (XFER_REQ1 === 1'b1) xfer1_n++;
	end
	// ****************
	// register bus cycles
	// ****************
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge MCLK);
		ADDR <= a; WDATA <= d; WR <= 1'b1;
		@(posedge MCLK);
		WR <= 1'b0;
		@(negedge MCLK);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge MCLK);
		ADDR <= a; RD <= 1'b1;
		@(posedge MCLK);
		RD <= 1'b0;
		@(negedge MCLK);
		d = RDATA;
	endtask : rd
	task automatic rdchk(input logic [7:0] a, input logic [15:0] e, input string n);
		logic [15:0] d;
		rd(a, d);
		`CHK(n, e, d)
	endtask : rdchk
	// ****************
	// scenarios
	// ****************
	task automatic t_reset;
		rdchk(`IOT_ADR_TCTL, 16'h0008, "tctl");
		rdchk(`IOT_ADR_COUNT, 16'h0000, "count");
		rdchk(8'h3f, 16'h0000, "unmapped");
		`CHK("irq", 1'b0, IRQ)
	endtask : t_reset
	task automatic t_load;
		wr(`IOT_ADR_COUNT, 16'h1234);
		rdchk(`IOT_ADR_COUNT, 16'h1234, "count");
		wr(`IOT_ADR_TCTL, 16'h0018);
		rdchk(`IOT_ADR_COUNT, 16'h0000, "count");
	endtask : t_load
	task automatic t_div;
		for (int d = 0; d < 4; d++) begin
			wr(`IOT_ADR_TCTL, 16'h0008 | 16'(d));
			wr(`IOT_ADR_TCTL, 16'(d));
			rd(`IOT_ADR_COUNT, v);
			repeat (8 * dv[d] - 2) @(posedge MCLK);
			rd(`IOT_ADR_COUNT, w);
			`CHK("ticks", 16'h0008, w - v)
		end
		wr(`IOT_ADR_TCTL, 16'h0008);
	endtask : t_div
	task automatic t_ovf;
		wr(`IOT_ADR_MASK, 16'h0001);
		wr(`IOT_ADR_COUNT, 16'hfffe);
		wr(`IOT_ADR_TCTL, 16'h0000);
		repeat (20) @(posedge MCLK);
		wr(`IOT_ADR_TCTL, 16'h0008);
		`CHK("irq", 1'b1, IRQ)
		rd(`IOT_ADR_COUNT, v);
		`CHK("wrap", 1'b1, v < 16'h0008)
		wr(`IOT_ADR_MASK, 16'h0000);
		`CHK("irq", 1'b0, IRQ)
		rd(`IOT_ADR_STAT, v);
		`CHK("ovf", 1'b1, v[`IOT_ST_OVF])
		wr(`IOT_ADR_STAT, 16'h001f);
		rd(`IOT_ADR_STAT, v);
		`CHK("ovf", 1'b0, v[`IOT_ST_OVF])
	endtask : t_ovf
	task automatic t_cmp;
		wr(`IOT_ADR_OCTL, 16'h0001);
		`CHK("pin0", 1'b1, CMP_OUT0)
		wr(`IOT_ADR_CMP0, 16'h0005);
		wr(`IOT_ADR_CMP1, 16'h0007);
		wr(`IOT_ADR_MASK, 16'h0006);
		wr(`IOT_ADR_OCTL, 16'h000d);
		wr(`IOT_ADR_TCTL, 16'h0018);
		wr(`IOT_ADR_TCTL, 16'h0000);
		repeat (50) @(posedge MCLK);
		wr(`IOT_ADR_TCTL, 16'h0008);
		`CHK("pins", 2'b01, {CMP_OUT1, CMP_OUT0} ^ 2'b11)
		rd(`IOT_ADR_STAT, v);
		`CHK("flags", 16'h0006, v & 16'h0006)
		`CHK("irq", 1'b1, IRQ)
		wr(`IOT_ADR_STAT, 16'h0006);
		`CHK("irq", 1'b0, IRQ)
		// compare 0 match wraps the count, so compare 1 never fires again
		wr(`IOT_ADR_TCTL, 16'h0018);
		wr(`IOT_ADR_TCTL, 16'h0004);
		repeat (100) @(posedge MCLK);
		wr(`IOT_ADR_TCTL, 16'h0008);
		rd(`IOT_ADR_COUNT, v);
		`CHK("clrmd", 1'b1, v <= 16'h0005)
		`CHK("pin1", 1'b1, CMP_OUT1)
		// paired: both matches invert pin 0, pin 1 stays
		wr(`IOT_ADR_OCTL, 16'h001d);
		wr(`IOT_ADR_TCTL, 16'h0018);
		t0 = tog0;
		t1 = tog1;
		wr(`IOT_ADR_TCTL, 16'h0000);
		repeat (50) @(posedge MCLK);
		wr(`IOT_ADR_TCTL, 16'h0008);
		`CHK("pair0", 8'h02, tog0 - t0)
		`CHK("pair1", 8'h00, tog1 - t1)
	endtask : t_cmp
	task automatic t_cap;
		wr(`IOT_ADR_ICTL, {12'h000, IOT_EDGE_FALL, IOT_EDGE_RISE});
		wr(`IOT_ADR_COUNT, 16'h0abc);
		wr(`IOT_ADR_STAT, 16'h001f);
		iot_pins_i.set_pin(0, 1'b1);
		iot_pins_i.set_pin(1, 1'b1);
		repeat (6) @(posedge MCLK);
		rdchk(`IOT_ADR_CAP0, 16'h0abc, "cap0");
		rdchk(`IOT_ADR_STAT, 16'h0008, "stat");
		wr(`IOT_ADR_MASK, 16'h0008);
		`CHK("irq", 1'b1, IRQ)
		iot_pins_i.set_pin(1, 1'b0);
		repeat (6) @(posedge MCLK);
		rdchk(`IOT_ADR_CAP1, 16'h0abc, "cap1");
		// software never writes a capture register; an unmapped write must leave it alone
		wr(8'h3f, 16'hffff);
		rdchk(`IOT_ADR_CAP1, 16'h0abc, "cap1");
		wr(`IOT_ADR_ICTL, {12'h000, IOT_EDGE_BOTH, IOT_EDGE_BOTH});
		wr(`IOT_ADR_COUNT, 16'h0123);
		iot_pins_i.set_pin(0, 1'b0);
		repeat (6) @(posedge MCLK);
		rdchk(`IOT_ADR_CAP0, 16'h0123, "cap0");
		// routed to the transfer service: pulse, no flag
		wr(`IOT_ADR_ICTL, 16'h003f);
		wr(`IOT_ADR_STAT, 16'h001f);
		x0 = xfer_n;
		x1 = xfer1_n;
		iot_pins_i.set_pin(0, 1'b1);
		iot_pins_i.set_pin(1, 1'b1);
		repeat (6) @(posedge MCLK);
		`CHK("xfer", 1, xfer_n - x0)
		`CHK("xfer1", 1, xfer1_n - x1)
		rdchk(`IOT_ADR_STAT, 16'h0000, "stat");
		// both channels off: a falling edge on pin 0 sets no flag
		wr(`IOT_ADR_ICTL, 16'h0000);
		iot_pins_i.set_pin(0, 1'b0);
		repeat (6) @(posedge MCLK);
		rdchk(`IOT_ADR_STAT, 16'h0000, "stat");
	endtask : t_cap
	// verdict and end of run
	task automatic summarize;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : summarize
	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge MCLK);
		err_total++;
		summarize();
	end
	// main sequence
	initial begin
		MCLK = 1'b0; RSTN = 1'b0; WR = 1'b0; RD = 1'b0; ADDR = 8'h00; WDATA = 16'h0000;
		err_total = 0; compares = 0; xfer_n = 0; xfer1_n = 0;
		repeat (3) @(posedge MCLK);
		RSTN <= 1'b1;
		t_reset();
		t_load();
		t_div();
		t_ovf();
		t_cmp();
		t_cap();
		summarize();
	end
endmodule : testbench
`default_nettype wire
